/* logic/acs_conv_seq.sv */
`timescale 1ns/10ps
// Notes on behaviour
// - a conversion completes when its result lands in both result registers, setting the done flag then.
// - when the done flag sets while the conversion interrupt enable is high, an interrupt is raised.
// - in 12 or 10 bit mode, after a high-result read and before the low-result read, a new result is dropped and the flag is not set.
// - a single conversion with compare on and the compare false just stops the converter, blocking or not.
// - otherwise a blocked transfer starts another conversion, single or continuous.
// - a write to status_control_one aborts and restarts, unless the channel field is all ones.
// - a write to status_control_two, the config or a compare value aborts the conversion as a mode change.
// - reset, or stop entry without the async conversion clock enabled, aborts the conversion.
// - an abort other than reset leaves the result registers as they were.
// - reset returns both result registers to their reset values.
// - the converter idles until started, and the async clock generator runs only with a conversion.
// - the low power bit reduces power and lowers the conversion clock rate.
// - sampling lasts 3.5 conversion clocks when short, 23.5 when long.
// - sampling begins on activation, then the input is released and approximation runs.
module acs_conv_seq import acs_pkg::*; #(
  parameter int unsigned HALF_DIV = 4
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  input wire logic stop_req,
  input wire logic afe_cmp_hi,
  output logic [4:0] afe_channel,
  output logic afe_sample,
  output logic [11:0] afe_trial,
  output logic aclk_gen_en,
  output logic low_power_en
);
  acs_sc1_t sc1_reg;
  logic [7:0] sc2_reg;
  acs_cfg_t cfg_reg;
  logic [11:0] cv_reg;
  logic [11:0] res_reg;
  logic done_flag_reg;
  logic lock_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_en_reg;

  logic acc;
  logic wr;
  logic rd;
  logic wr_sc1;
  logic wr_mode;
  logic rd_high;
  logic rd_low;
  logic stop_sync;
  logic cmp_sync;
  logic stop_abort;
  logic eng_start;
  logic eng_abort;
  logic eng_busy;
  logic eng_sampling;
  logic eng_done;
  logic eng_done_ok;
  logic [11:0] eng_trial;
  logic [11:0] eng_result;
  logic cmp_en;
  logic cmp_true;
  logic cmp_fail;
  logic blocked;
  logic xfer;
  logic rerun;
  logic [IRQ_W-1:0] irq_evt;

  // access completes on the edge where ack is seen high
  assign acc = wb_cyc_i && wb_stb_i && wb_ack_o;
  assign wr = acc && wb_we_i && wb_sel_i[0];
  assign rd = acc && !wb_we_i;
  assign wr_sc1 = wr && wb_adr_i == OFS_SC1;
  assign wr_mode = wr && (wb_adr_i == OFS_SC2 || wb_adr_i == OFS_CFG ||
                          wb_adr_i == OFS_CV_HIGH || wb_adr_i == OFS_CV_LOW);
  assign rd_high = rd && wb_adr_i == OFS_RES_HIGH;
  assign rd_low = rd && wb_adr_i == OFS_RES_LOW;

  assign stop_abort = stop_sync && !cfg_reg.aclk;
  // every write to status_control_one, status_control_two, the config or a compare value aborts; only a real channel code restarts the engine
  assign eng_abort = wr_mode || wr_sc1 || stop_abort;
  // a write landing with the final edge wins: its result is discarded
  assign eng_done_ok = eng_done && !eng_abort && !wr_sc1;

  assign cmp_en = sc2_reg[SC2_CMP_EN_BIT];
  assign cmp_true = sc2_reg[SC2_CMP_GE_BIT] ? (eng_result >= cv_reg) : (eng_result < cv_reg);
  assign cmp_fail = cmp_en && !cmp_true;
  assign blocked = lock_reg && cfg_reg.mode != MODE_8;
  assign xfer = eng_done_ok && !cmp_fail && !blocked;
  // a failed compare in single mode ends here, ahead of any blocking
  assign rerun = eng_done_ok && (cmp_fail ? sc1_reg.cont : (blocked || sc1_reg.cont));
  assign eng_start = (wr_sc1 && wb_dat_i[SC1_CH_LSB +: CH_W] != CH_IDLE) ||
                     (rerun && !stop_abort);

  assign irq_evt[IRQ_DONE_BIT] = xfer && sc1_reg.conversion_irq_enable;
  assign irq_evt[IRQ_DROP_BIT] = eng_done_ok && blocked && !cmp_fail;

  acs_sync3 u_stop_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .din(stop_req),
    .dout(stop_sync)
  );

  acs_sync3 u_cmp_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .din(afe_cmp_hi),
    .dout(cmp_sync)
  );

  acs_sar_engine #(
    .HALF_DIV(HALF_DIV)
  ) u_engine (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(eng_start),
    .abort(eng_abort),
    .cfg(cfg_reg),
    .cmp_hi(cmp_sync),
    .busy(eng_busy),
    .sampling(eng_sampling),
    .trial(eng_trial),
    .done(eng_done),
    .result(eng_result)
  );

  // bus answer: ack one cycle after the request, unmapped reads give zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= 32'h0000_0000;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) begin
        unique case (wb_adr_i)
          OFS_SC1: wb_dat_o <= 32'({done_flag_reg, sc1_reg});
          // busy shows in the top bit, compare controls keep their places
          OFS_SC2: wb_dat_o <= 32'({eng_busy, sc2_reg[6:0]});
          OFS_CFG: wb_dat_o <= 32'({cfg_reg.lpc, 2'h0, cfg_reg.lsmp, cfg_reg.mode, 1'b0,
                                    cfg_reg.aclk});
          OFS_RES_HIGH: wb_dat_o <= 32'(res_reg[11:8]);
          OFS_RES_LOW: wb_dat_o <= 32'(res_reg[7:0]);
          OFS_CV_HIGH: wb_dat_o <= 32'(cv_reg[11:8]);
          OFS_CV_LOW: wb_dat_o <= 32'(cv_reg[7:0]);
          OFS_IRQ_STAT: wb_dat_o <= 32'(irq_stat_reg);
          OFS_IRQ_EN: wb_dat_o <= 32'(irq_en_reg);
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sc1_reg <= acs_sc1_t'(SC1_RST[6:0]);
      sc2_reg <= SC2_RST;
      cfg_reg <= acs_cfg_t'({CFG_RST[7], CFG_RST[4:2], CFG_RST[0]});
      cv_reg <= CV_RST;
      irq_en_reg <= '0;
    end else if (wr) begin
      unique case (wb_adr_i)
        OFS_SC1: sc1_reg <= acs_sc1_t'(wb_dat_i[6:0]);
        OFS_SC2: sc2_reg <= {2'h0, wb_dat_i[5:4], 4'h0};
        OFS_CFG: cfg_reg <= acs_cfg_t'({wb_dat_i[CFG_LPC_BIT], wb_dat_i[CFG_LSMP_BIT],
                                        wb_dat_i[CFG_MODE_LSB +: 2], wb_dat_i[CFG_ACLK_BIT]});
        OFS_CV_HIGH: cv_reg[11:8] <= wb_dat_i[3:0];
        OFS_CV_LOW: cv_reg[7:0] <= wb_dat_i[7:0];
        OFS_IRQ_EN: irq_en_reg <= wb_dat_i[IRQ_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // results change only on a completed transfer, so aborts keep old data
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      res_reg <= RES_RST;
    end else if (xfer) begin
      res_reg <= eng_result;
    end
  end

  // hardware set wins over the clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      done_flag_reg <= 1'b0;
    end else if (xfer) begin
      done_flag_reg <= 1'b1;
    end else if (rd_low || wr_sc1) begin
      done_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lock_reg <= 1'b0;
    end else if (rd_low || wr_sc1) begin
      lock_reg <= 1'b0;
    end else if (rd_high && cfg_reg.mode != MODE_8) begin
      lock_reg <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_stat_reg <= '0;
    end else begin
      irq_stat_reg <= irq_evt |
        (irq_stat_reg & ~((wr && wb_adr_i == OFS_IRQ_CLR) ? wb_dat_i[IRQ_W-1:0] : '0));
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_o <= 1'b0;
      afe_channel <= CH_IDLE;
      afe_sample <= 1'b0;
      afe_trial <= 12'h000;
      aclk_gen_en <= 1'b0;
      low_power_en <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_reg & irq_en_reg);
      afe_channel <= sc1_reg.ch;
      afe_sample <= eng_sampling;
      afe_trial <= eng_trial;
      aclk_gen_en <= eng_busy && cfg_reg.aclk;
      low_power_en <= eng_busy && cfg_reg.lpc;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_done_result: assert property (xfer |=> done_flag_reg && res_reg == $past(eng_result))
    else $error("completion did not load result and flag");

  a_irq_on_done: assert property (xfer && sc1_reg.conversion_irq_enable |=> irq_stat_reg[IRQ_DONE_BIT])
    else $error("completion interrupt missing");

  a_block_drop: assert property (
    eng_done_ok && blocked && !xfer && !rd_low && !wr_sc1 |=>
      res_reg == $past(res_reg) && done_flag_reg == $past(done_flag_reg))
    else $error("blocked result was transferred");

  a_compare_stop: assert property (
    eng_done_ok && cmp_fail && !sc1_reg.cont && !wr_sc1 |=> !eng_busy)
    else $error("failed compare did not stop converter");

  a_block_rerun: assert property (
    eng_done_ok && blocked && !cmp_fail && !stop_abort |=> eng_busy ##1 afe_sample)
    else $error("blocked transfer did not restart");

  a_sc1_restart: assert property (
    wr_sc1 && wb_dat_i[4:0] != CH_IDLE |=> eng_sampling && !done_flag_reg)
    else $error("control write did not restart");

  a_mode_abort: assert property (wr_mode && !wr_sc1 |=> !eng_busy ##1 !afe_sample)
    else $error("mode write did not abort");

  a_stop_abort: assert property (stop_abort && !eng_start |=> !eng_busy)
    else $error("stop entry did not abort");

  a_abort_keep: assert property (eng_abort |=> res_reg == $past(res_reg))
    else $error("abort changed the results");

  a_low_read_clr: assert property (rd_low && !xfer |=> !done_flag_reg && !lock_reg)
    else $error("low read did not clear flag and block");

  a_aclk_idle: assert property (!eng_busy |=> !aclk_gen_en)
    else $error("async clock enabled while idle");

  a_idle_stop: assert property (
    wr_sc1 && wb_dat_i[SC1_CH_LSB +: CH_W] == CH_IDLE |=> !eng_busy)
    else $error("idle channel write did not stop converter");

  a_stay_idle: assert property (!eng_busy && !eng_start |=> !eng_busy)
    else $error("converter left idle without a start");

  a_lowpwr_idle: assert property (!eng_busy |=> !low_power_en)
    else $error("low power condition while idle");

  a_result_hold: assert property (!xfer |=> res_reg == $past(res_reg))
    else $error("results changed without a transfer");

  a_irq_raise: assert property (|(irq_stat_reg & irq_en_reg) |=> irq_o)
    else $error("interrupt output missing");

  a_irq_drop: assert property (!(|(irq_stat_reg & irq_en_reg)) |=> !irq_o)
    else $error("interrupt output without enabled status");

endmodule

/* logic/acs_pkg.sv */
package acs_pkg;

  // register byte offsets on the bus
  localparam logic [5:0] OFS_SC1 = 6'h00;
  localparam logic [5:0] OFS_SC2 = 6'h04;
  localparam logic [5:0] OFS_CFG = 6'h08;
  localparam logic [5:0] OFS_RES_HIGH = 6'h0c;
  localparam logic [5:0] OFS_RES_LOW = 6'h10;
  localparam logic [5:0] OFS_CV_HIGH = 6'h14;
  localparam logic [5:0] OFS_CV_LOW = 6'h18;
  localparam logic [5:0] OFS_IRQ_STAT = 6'h1c;
  localparam logic [5:0] OFS_IRQ_EN = 6'h20;
  localparam logic [5:0] OFS_IRQ_CLR = 6'h24;

  // status_control_one fields
  localparam int unsigned SC1_CH_LSB = 0;
  localparam int unsigned CH_W = 5;
  localparam int unsigned SC1_CONT_BIT = 5;
  localparam int unsigned SC1_CONVERSION_IRQ_ENABLE_BIT = 6;
  localparam int unsigned SC1_DONE_BIT = 7;
  localparam logic [4:0] CH_IDLE = 5'h1f;

  // status_control_two fields
  localparam int unsigned SC2_CMP_GE_BIT = 4;
  localparam int unsigned SC2_CMP_EN_BIT = 5;

  // converter_config_reg fields
  localparam int unsigned CFG_ACLK_BIT = 0;
  localparam int unsigned CFG_MODE_LSB = 2;
  localparam int unsigned CFG_LSMP_BIT = 4;
  localparam int unsigned CFG_LPC_BIT = 7;
  localparam logic [1:0] MODE_8 = 2'h0;
  localparam logic [1:0] MODE_12 = 2'h1;
  localparam logic [1:0] MODE_10 = 2'h2;

  // reset values
  localparam logic [7:0] SC1_RST = 8'h1f;
  localparam logic [7:0] SC2_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [11:0] RES_RST = 12'h000;
  localparam logic [11:0] CV_RST = 12'h000;

  // interrupt status bits
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned IRQ_DONE_BIT = 0;
  localparam int unsigned IRQ_DROP_BIT = 1;

  // sample phase, tenths of a conversion-clock cycle, then in half cycles
  localparam int unsigned SAMPLE_SHORT_X10 = 35;
  localparam int unsigned SAMPLE_LONG_X10 = 235;
  localparam logic [5:0] SAMPLE_SHORT_HALF = 6'((SAMPLE_SHORT_X10 * 2) / 10);
  localparam logic [5:0] SAMPLE_LONG_HALF = 6'((SAMPLE_LONG_X10 * 2) / 10);
  localparam logic [5:0] SYNC_HALF = 6'h04;

  typedef struct packed {
    logic lpc;
    logic lsmp;
    logic [1:0] mode;
    logic aclk;
  } acs_cfg_t;

  typedef struct packed {
    logic conversion_irq_enable;
    logic cont;
    logic [4:0] ch;
  } acs_sc1_t;

  function automatic logic [3:0] acs_res_bits(input logic [1:0] mode);
    acs_res_bits = (mode == MODE_12) ? 4'hc : (mode == MODE_10) ? 4'ha : 4'h8;
  endfunction

endpackage

/* logic/acs_sar_engine.sv */
`timescale 1ns/10ps
module acs_sar_engine import acs_pkg::*; #(
  parameter int unsigned HALF_DIV = 4
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic abort,
  input wire acs_cfg_t cfg,
  input wire logic cmp_hi,
  output logic busy,
  output logic sampling,
  output logic [11:0] trial,
  output logic done,
  output logic [11:0] result
);
  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONV, ST_SYNC} acs_eng_t;

  acs_eng_t state_reg;
  logic [7:0] div_reg;
  logic [7:0] div_lim;
  logic half_tick;
  logic [5:0] cnt_reg;
  logic [5:0] samp_half;
  logic [3:0] bit_reg;
  logic phase_reg;
  logic [15:0] samp_cyc_reg;

  // low power halves the conversion clock rate
  assign div_lim = cfg.lpc ? 8'(2 * HALF_DIV) : 8'(HALF_DIV);
  assign half_tick = (div_reg == div_lim - 8'h01);
  assign samp_half = cfg.lsmp ? SAMPLE_LONG_HALF : SAMPLE_SHORT_HALF;

  always_ff @(posedge sys_clk) begin
    if (rst || start || half_tick) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 6'h00;
      bit_reg <= 4'h0;
      phase_reg <= 1'b0;
      trial <= 12'h000;
      result <= RES_RST;
      done <= 1'b0;
      busy <= 1'b0;
      sampling <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        state_reg <= ST_SAMPLE;
        cnt_reg <= 6'h00;
        trial <= 12'h000;
        busy <= 1'b1;
        sampling <= 1'b1;
      end else if (abort) begin
        state_reg <= ST_IDLE;
        trial <= 12'h000;
        busy <= 1'b0;
        sampling <= 1'b0;
      end else if (half_tick) begin
        unique case (state_reg)
          ST_IDLE: begin
          end
          ST_SAMPLE: begin
            cnt_reg <= cnt_reg + 6'h01;
            if (cnt_reg == samp_half - 6'h01) begin
              // input is released on the same edge that drives the first trial
              state_reg <= ST_CONV;
              sampling <= 1'b0;
              bit_reg <= acs_res_bits(cfg.mode) - 4'h1;
              trial[acs_res_bits(cfg.mode) - 4'h1] <= 1'b1;
              phase_reg <= 1'b0;
            end
          end
          ST_CONV: begin
            phase_reg <= ~phase_reg;
            if (phase_reg) begin
              if (!cmp_hi) begin
                trial[bit_reg] <= 1'b0;
              end
              if (bit_reg == 4'h0) begin
                state_reg <= ST_SYNC;
                cnt_reg <= 6'h00;
              end else begin
                bit_reg <= bit_reg - 4'h1;
                trial[bit_reg - 4'h1] <= 1'b1;
              end
            end
          end
          ST_SYNC: begin
            cnt_reg <= cnt_reg + 6'h01;
            if (cnt_reg == SYNC_HALF - 6'h01) begin
              state_reg <= ST_IDLE;
              result <= trial;
              done <= 1'b1;
              busy <= 1'b0;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || start) begin
      samp_cyc_reg <= 16'h0000;
    end else if (sampling) begin
      samp_cyc_reg <= samp_cyc_reg + 16'h0001;
    end
  end

  a_sample_len: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(sampling) && state_reg == ST_CONV |->
      samp_cyc_reg == 16'(samp_half) * 16'(div_lim))
    else $error("sample phase length wrong");

  a_isolate_first: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(sampling) && state_reg == ST_CONV |-> trial != 12'h000 && busy)
    else $error("conversion did not follow sampling");

endmodule

/* logic/acs_sync3.sv */
`timescale 1ns/10ps
module acs_sync3 (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // a change is only accepted once the last two stages agree
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        dout <= s3_reg;
      end
    end
  end
endmodule

/* testbench/acs_afe_model.sv */
`timescale 1ns/10ps
module acs_afe_model (
  input wire logic sys_clk,
  input wire logic [11:0] vin,
  input wire logic afe_sample,
  input wire logic [11:0] afe_trial,
  output logic afe_cmp_hi
);
  logic [11:0] held_reg = 12'h000;
  // track while connected, hold once released so a late input change cannot leak in
  always @(posedge sys_clk) begin
    if (afe_sample === 1'b1) begin
      held_reg <= vin;
    end
  end
  // comparator high when the held level is at or above the trial code
  assign afe_cmp_hi = (held_reg >= afe_trial);
endmodule

/* testbench/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import acs_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, stop_req = 1'b0;
  logic [5:0] wb_adr_i = 6'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic wb_ack_o, irq_o, afe_cmp_hi, afe_sample, aclk_gen_en, low_power_en;
  logic lp_seen, ck_seen;
  logic [4:0] afe_channel;
  logic [11:0] afe_trial, vin = 12'h000;
  int err_total = 0, cmp_count = 0, cyc_n = 0, samp_run = 0, samp_len = 0;
  int conv_run = 0, conv_len = 0;
  int seed = 32'h384df8b6, exp_hi = 0, exp_lo = 0, nb = 12;
  logic [5:0] ab[5] = '{OFS_SC2, OFS_CFG, OFS_CV_HIGH, OFS_CV_LOW, OFS_SC1};
  logic [7:0] db[5] = '{8'h00, 8'h05, 8'h00, 8'h00, 8'h1f};

  always #5 sys_clk = ~sys_clk;

  acs_conv_seq #(.HALF_DIV(4)) acs_conv_seq_i (.sys_clk, .rst, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .stop_req,
    .afe_cmp_hi, .afe_channel, .afe_sample, .afe_trial, .aclk_gen_en, .low_power_en);
  acs_afe_model acs_afe_model_i (.sys_clk, .vin, .afe_sample, .afe_trial, .afe_cmp_hi);

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // sample phase length and power pins, watched while the input is connected
  always @(posedge sys_clk) begin
    cyc_n <= cyc_n + 1;
    if (afe_sample === 1'b1) begin
      samp_run <= samp_run + 1;
      lp_seen <= low_power_en;
      ck_seen <= aclk_gen_en;
    end else if (samp_run != 0) begin
      samp_len <= samp_run;
      samp_run <= 0;
    end
    if (aclk_gen_en === 1'b1) begin
      conv_run <= conv_run + 1;
    end else if (conv_run != 0) begin
      conv_len <= conv_run;
      conv_run <= 0;
    end
    if (cyc_n == 60000) begin
      err_total = err_total + 1;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic bus(input logic we, input logic [5:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= {3'($random(seed)), 1'b1};
    wb_dat_i <= d;
    // only the bench timeout ends a wait for ack
    do begin
      @(posedge sys_clk);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic poll(input logic [5:0] a, input int b, input logic v);
    int n;
    n = 0;
    do begin
      bus(1'b0, a, 32'h0);
      n++;
    end while (q[b] !== v && n < 600);
  endtask

  task automatic start(input logic [7:0] sc1);
    vin <= 12'($random(seed)) & 12'((1 << nb) - 1);
    bus(1'b1, OFS_SC1, {24'h0, sc1});
  endtask

  task automatic set_exp();
    exp_hi = vin >> 8;
    exp_lo = vin & 12'h0ff;
  endtask

  // reading the low half also releases any read block left behind
  task automatic chk_res();
    bus(1'b0, OFS_RES_HIGH, 32'h0);
    chk(q, exp_hi);
    bus(1'b0, OFS_RES_LOW, 32'h0);
    chk(q, exp_lo);
  endtask

  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    chk(afe_channel, CH_IDLE);
    chk(aclk_gen_en, 1'b0);
    chk_res();
    $display("reset test done");
    bus(1'b1, OFS_IRQ_EN, 32'h3);
    for (int i = 0; i < 3; i++) begin
      nb = (i == 0) ? 8 : (i == 1) ? 12 : 10;
      bus(1'b1, OFS_CFG, {24'h0, i == 2, 2'b00, i[0], 2'(i), 1'b0, 1'b1});
      start(8'h40 | 8'(i));
      set_exp();
      poll(OFS_SC1, 7, 1'b1);
      chk(q[7], 1'b1);
      chk(samp_len, (i[0] ? 47 : 7) * (i == 2 ? 8 : 4));
      chk(lp_seen, i == 2);
      chk(ck_seen, 1'b1);
      chk(afe_channel, 5'(i));
      chk(irq_o, 1'b1);
      chk_res();
      chk(conv_len, ((i[0] ? 47 : 7) + 2 * nb + SYNC_HALF) * (i == 2 ? 8 : 4));
      bus(1'b0, OFS_SC1, 32'h0);
      chk(q[7], 1'b0);
      bus(1'b0, OFS_IRQ_STAT, 32'h0);
      chk(q, 32'h1);
      bus(1'b1, OFS_IRQ_CLR, 32'h3);
      bus(1'b0, OFS_IRQ_STAT, 32'h0);
      chk(q, 32'h0);
      chk(irq_o, 1'b0);
    end
    $display("resolution test done");
    nb = 12;
    bus(1'b1, OFS_CFG, 32'h05);
    start(8'h03);
    // high half read early on purpose, so the first result must be dropped
    bus(1'b0, OFS_RES_HIGH, 32'h0);
    poll(OFS_IRQ_STAT, 1, 1'b1);
    chk(q[1], 1'b1);
    bus(1'b0, OFS_SC1, 32'h0);
    chk(q[7], 1'b0);
    bus(1'b0, OFS_RES_LOW, 32'h0);
    set_exp();
    poll(OFS_SC1, 7, 1'b1);
    chk(q[7], 1'b1);
    chk_res();
    bus(1'b0, OFS_IRQ_STAT, 32'h0);
    chk(q, 32'h2);
    bus(1'b1, OFS_IRQ_CLR, 32'h3);
    bus(1'b1, OFS_SC2, 32'h20);
    bus(1'b1, OFS_CV_HIGH, 32'h0);
    bus(1'b1, OFS_CV_LOW, 32'h0);
    start(8'h04);
    bus(1'b0, OFS_RES_HIGH, 32'h0);
    poll(OFS_SC2, 7, 1'b0);
    chk(q[7], 1'b0);
    chk(q[5], 1'b1);
    bus(1'b0, OFS_IRQ_STAT, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, OFS_SC2, 32'h00);
    $display("blocking test done");
    for (int k = 0; k < 5; k++) begin
      start(8'h45);
      bus(1'b1, ab[k], {24'h0, db[k]});
      poll(OFS_SC2, 7, 1'b0);
      chk(q[7], 1'b0);
      chk_res();
      bus(1'b0, OFS_SC1, 32'h0);
      chk(q[7], 1'b0);
    end
    bus(1'b1, OFS_CFG, 32'h04);
    start(8'h46);
    stop_req <= 1'b1;
    poll(OFS_SC2, 7, 1'b0);
    chk(q[7], 1'b0);
    chk_res();
    stop_req <= 1'b0;
    // let the stop synchroniser drain before the next start
    repeat (6) @(posedge sys_clk);
    $display("abort test done");
    start(8'h46);
    set_exp();
    poll(OFS_SC1, 7, 1'b1);
    chk_res();
    start(8'h46);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    exp_hi = 0;
    exp_lo = 0;
    chk(afe_channel, CH_IDLE);
    chk_res();
    $display("mid-run reset test done");
    report_and_stop();
  end
endmodule
